// ### logic/dsgc_pkg.sv
// shared constants and types of the port clock gating block
package dsgc_pkg;

	// ****************************************************************
	// widths
	// ****************************************************************
	localparam int unsigned data_w  = 32;
	localparam int unsigned addr_w  = 12;
	localparam int unsigned ports_w = 8;
	localparam int unsigned field_w = 8;

	// ****************************************************************
	// register offsets (byte addresses, low bits of paddr)
	// ****************************************************************
	localparam logic [addr_w-1:0] off_run_clock_configuration = 12'h060;
	localparam logic [addr_w-1:0] off_run_port_clock_gate     = 12'h108;
	localparam logic [addr_w-1:0] off_sleep_port_clock_gate   = 12'h118;
	localparam logic [addr_w-1:0] off_deep_sleep_port_clock_gate = 12'h128;
	localparam logic [addr_w-1:0] off_event_status            = 12'h200;
	localparam logic [addr_w-1:0] off_event_mask              = 12'h204;

	// ****************************************************************
	// fields and reset values
	// ****************************************************************
	localparam int unsigned         auto_clock_gating_select_bit = 0;
	localparam logic [field_w-1:0]  gate_reset     = 8'h00;
	localparam logic [field_w-1:0]  mask_reset     = 8'h00;
	localparam logic                acg_reset      = 1'b0;
	localparam logic [23:0]         reserved_zero  = 24'h00_0000;
	localparam logic [30:0]         cfg_zero       = 31'h0000_0000;
	localparam logic [data_w-1:0]   data_zero      = 32'h0000_0000;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic [1:0] {
		power_run,
		power_sleep,
		power_deep
	} dsgc_power_t;

	typedef enum logic [2:0] {
		reg_none,
		reg_run_cfg,
		reg_run_gate,
		reg_sleep_gate,
		reg_deep_gate,
		reg_status,
		reg_mask
	} dsgc_reg_t;

	function automatic dsgc_reg_t dsgc_decode(input logic [addr_w-1:0] addr);
		dsgc_reg_t r;
		r = reg_none;
		case (addr)
			off_run_clock_configuration:    r = reg_run_cfg;
			off_run_port_clock_gate:        r = reg_run_gate;
			off_sleep_port_clock_gate:      r = reg_sleep_gate;
			off_deep_sleep_port_clock_gate: r = reg_deep_gate;
			off_event_status:               r = reg_status;
			off_event_mask:                 r = reg_mask;
			default:                        r = reg_none;
		endcase
		return r;
	endfunction : dsgc_decode

endpackage : dsgc_pkg

// ### logic/dsgc_gate_select.sv
// picks the port gating word that applies in the present power state
`timescale 1ns/1ns
`default_nettype none
module dsgc_gate_select (
	// power state and mode
	input  wire dsgc_pkg::dsgc_power_t power_state,
	input  wire logic                  auto_clock_gating_select,
	// the three gating words
	input  wire logic [7:0]            run_port_clock_gate,
	input  wire logic [7:0]            sleep_port_clock_gate,
	input  wire logic [7:0]            deep_sleep_port_clock_gate,
	// chosen word
	output logic [7:0]                 active_gate
);

	always_comb begin
		active_gate = run_port_clock_gate;
		// without automatic gating the run word rules in every state
		if (auto_clock_gating_select) begin
			case (power_state)
				dsgc_pkg::power_run:   active_gate = run_port_clock_gate;
				dsgc_pkg::power_sleep: active_gate = sleep_port_clock_gate;
				dsgc_pkg::power_deep:  active_gate = deep_sleep_port_clock_gate;
				default:               active_gate = run_port_clock_gate;
			endcase
		end
	end

endmodule : dsgc_gate_select
`default_nettype wire

// ### logic/dsgc_event_status.sv
// sticky event status with mask and one level interrupt
`timescale 1ns/1ns
`default_nettype none
module dsgc_event_status (
	// clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// events and software control
	input  wire logic [7:0] event_set,
	input  wire logic [7:0] event_clear,
	input  wire logic [7:0] event_mask,
	// state
	output logic [7:0]      event_status,
	output logic            irq
);

	typedef struct packed {
		logic [7:0] status;
		logic       irq;
	} dsgc_status_state_t;

	dsgc_status_state_t q;
	dsgc_status_state_t next_q;

	always_comb begin
		next_q = q;
		// set beats a clear landing in the same cycle
		next_q.status = (q.status & ~event_clear) | event_set;
		next_q.irq    = |(next_q.status & event_mask);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign event_status = q.status;
	assign irq          = q.irq;

endmodule : dsgc_event_status
`default_nettype wire

// ### logic/dsgc_top.sv
// deep-sleep port clock gating register block with apb slave
`timescale 1ns/1ns
`default_nettype none
module dsgc_top (
	// clock and reset
	input  wire logic                       pclk,
	input  wire logic                       presetn,
	// apb slave
	input  wire logic                       psel,
	input  wire logic                       penable,
	input  wire logic                       pwrite,
	input  wire logic [dsgc_pkg::addr_w-1:0] paddr,
	input  wire logic [dsgc_pkg::data_w-1:0] pwdata,
	input  wire logic [3:0]                 pstrb,
	output logic                            pready,
	output logic [dsgc_pkg::data_w-1:0]     prdata,
	output logic                            pslverr,
	// power state from the power controller
	input  wire dsgc_pkg::dsgc_power_t      power_state,
	// port side
	input  wire logic [7:0]                 port_access,
	output logic [7:0]                      port_clock_enable,
	output logic [7:0]                      port_bus_fault,
	// interrupt
	output logic                            irq
);

	// ****************************************************************
	// state
	// ****************************************************************
	typedef struct packed {
		logic [7:0]                  run_port_clock_gate;
		logic [7:0]                  sleep_port_clock_gate;
		logic [7:0]                  deep_sleep_port_clock_gate;
		logic                        auto_clock_gating_select;
		logic [7:0]                  event_mask;
		logic                        pready;
		logic [dsgc_pkg::data_w-1:0] prdata;
		logic                        pslverr;
		logic [7:0]                  port_clock_enable;
		logic [7:0]                  port_bus_fault;
	} dsgc_top_state_t;

	dsgc_top_state_t q;
	dsgc_top_state_t next_q;

	logic [7:0]          active_gate;
	logic [7:0]          event_status;
	logic [7:0]          event_clear;
	logic                status_irq;
	dsgc_pkg::dsgc_reg_t setup_reg;
	dsgc_pkg::dsgc_reg_t access_reg;
	logic                setup_phase;
	logic                write_commit;

	// ****************************************************************
	// submodules
	// ****************************************************************
	dsgc_gate_select u_select (
		.power_state                (power_state),
		.auto_clock_gating_select   (q.auto_clock_gating_select),
		.run_port_clock_gate        (q.run_port_clock_gate),
		.sleep_port_clock_gate      (q.sleep_port_clock_gate),
		.deep_sleep_port_clock_gate (q.deep_sleep_port_clock_gate),
		.active_gate                (active_gate)
	);

	dsgc_event_status u_status (
		.pclk         (pclk),
		.presetn      (presetn),
		.event_set    (q.port_bus_fault),
		.event_clear  (event_clear),
		.event_mask   (q.event_mask),
		.event_status (event_status),
		.irq          (status_irq)
	);

	// ****************************************************************
	// bus decode
	// ****************************************************************
	assign setup_phase  = psel & ~penable;
	assign setup_reg    = dsgc_pkg::dsgc_decode(paddr);
	assign access_reg   = dsgc_pkg::dsgc_decode(paddr);
	// only byte lane 0 carries field bits; a faulted access writes nothing
	assign write_commit = psel & penable & q.pready & pwrite & ~q.pslverr & pstrb[0];
	assign event_clear  = (write_commit && access_reg == dsgc_pkg::reg_status) ?
	                      pwdata[dsgc_pkg::field_w-1:0] : dsgc_pkg::gate_reset;

	// ****************************************************************
	// next state
	// ****************************************************************
	always_comb begin
		next_q = q;

		// one wait-free access phase: ready is raised for the cycle after setup
		next_q.pready  = setup_phase;
		next_q.pslverr = setup_phase & (setup_reg == dsgc_pkg::reg_none);
		next_q.prdata  = dsgc_pkg::data_zero;
		if (setup_phase && !pwrite) begin
			case (setup_reg)
				dsgc_pkg::reg_run_cfg:
					next_q.prdata = {dsgc_pkg::cfg_zero, q.auto_clock_gating_select};
				dsgc_pkg::reg_run_gate:
					next_q.prdata = {dsgc_pkg::reserved_zero, q.run_port_clock_gate};
				dsgc_pkg::reg_sleep_gate:
					next_q.prdata = {dsgc_pkg::reserved_zero, q.sleep_port_clock_gate};
				dsgc_pkg::reg_deep_gate:
					next_q.prdata = {dsgc_pkg::reserved_zero,
					                 q.deep_sleep_port_clock_gate};
				dsgc_pkg::reg_status:
					next_q.prdata = {dsgc_pkg::reserved_zero, event_status};
				dsgc_pkg::reg_mask:
					next_q.prdata = {dsgc_pkg::reserved_zero, q.event_mask};
				default:
					next_q.prdata = dsgc_pkg::data_zero;
			endcase
		end

		// reserved bits are dropped on write, so they stay zero
		if (write_commit) begin
			case (access_reg)
				dsgc_pkg::reg_run_cfg:
					next_q.auto_clock_gating_select =
						pwdata[dsgc_pkg::auto_clock_gating_select_bit];
				dsgc_pkg::reg_run_gate:
					next_q.run_port_clock_gate = pwdata[dsgc_pkg::field_w-1:0];
				dsgc_pkg::reg_sleep_gate:
					next_q.sleep_port_clock_gate = pwdata[dsgc_pkg::field_w-1:0];
				dsgc_pkg::reg_deep_gate:
					next_q.deep_sleep_port_clock_gate =
						pwdata[dsgc_pkg::field_w-1:0];
				dsgc_pkg::reg_mask:
					next_q.event_mask = pwdata[dsgc_pkg::field_w-1:0];
				default: ;
			endcase
		end

		// registered enable: ports run on pclk with this as clock enable,
		// so no shortened pulse can reach them when the bit flips
		next_q.port_clock_enable = active_gate;

		// a port held disabled refuses its access and faults the master
		next_q.port_bus_fault = port_access & ~q.port_clock_enable;
	end

	// ****************************************************************
	// registers
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q.run_port_clock_gate        <= dsgc_pkg::gate_reset;
			q.sleep_port_clock_gate      <= dsgc_pkg::gate_reset;
			q.deep_sleep_port_clock_gate <= dsgc_pkg::gate_reset;
			q.auto_clock_gating_select   <= dsgc_pkg::acg_reset;
			q.event_mask                 <= dsgc_pkg::mask_reset;
			q.pready                     <= 1'b0;
			q.prdata                     <= dsgc_pkg::data_zero;
			q.pslverr                    <= 1'b0;
			q.port_clock_enable          <= dsgc_pkg::gate_reset;
			q.port_bus_fault             <= dsgc_pkg::gate_reset;
		end else begin
			q <= next_q;
		end
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	assign pready            = q.pready;
	assign prdata            = q.prdata;
	assign pslverr           = q.pslverr;
	assign port_clock_enable = q.port_clock_enable;
	assign port_bus_fault    = q.port_bus_fault;
	assign irq               = status_irq;

endmodule : dsgc_top
`default_nettype wire

// ### testbench/dsgc_chk_sva.sv
// concurrent checks on the ports of the port clock gating block
`timescale 1ns/1ns
`default_nettype none
module dsgc_chk (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [11:0] paddr,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// port side
	input wire logic [7:0]  port_access,
	input wire logic [7:0]  port_clock_enable,
	input wire logic [7:0]  port_bus_fault
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic mapped;
	// independent copy of the map, so a decode slip shows
	assign mapped = paddr inside {12'h060, 12'h108, 12'h118, 12'h128, 12'h200, 12'h204};
	AST_SETUP_ANSWER: assert property (psel && !penable |=> pready)
		else $error("no pready after setup");
	AST_PREADY_ONE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_UNMAPPED: assert property (pready |-> pslverr == !mapped)
		else $error("pslverr does not match decode");
	AST_ERR_ALONE: assert property (pslverr |-> pready)
		else $error("pslverr without pready");
	AST_RESERVED: assert property (pready |-> prdata[31:8] == 24'h00_0000)
		else $error("reserved bits not zero");
	AST_IDLE_DATA: assert property (!pready |-> prdata == 32'h0000_0000)
		else $error("prdata outside access");
	AST_FAULT: assert property (1'b1 |=> port_bus_fault == $past(port_access & ~port_clock_enable))
		else $error("fault pulse wrong");
	AST_RESET_CLEAR: assert property ($rose(presetn) |-> port_clock_enable == 8'h00)
		else $error("enables not clear after reset");
	COV_FAULT: cover property (port_bus_fault != 8'h00);
	COV_ERR: cover property (pready && pslverr);
	COV_RESET: cover property ($rose(presetn));
endmodule : dsgc_chk
bind dsgc_top dsgc_chk u_chk (.pclk, .presetn, .psel, .penable, .paddr, .pready, .prdata,
	.pslverr, .port_access, .port_clock_enable, .port_bus_fault);
`default_nettype wire

// ### testbench/dsgc_top_tb.sv
// self-checking bench for the port clock gating block
`timescale 1ns/1ns
`default_nettype none
module dsgc_top_tb;
	typedef struct {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] q; logic e;} dsgc_row_t;
	logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pclk;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic [3:0]  pstrb = 4'hF;
	logic [7:0]  port_access = 8'h00, port_clock_enable, port_bus_fault;
	logic        pready, pslverr, irq, er;
	int          bad_count = 0, cmp_count = 0, i;
	dsgc_pkg::dsgc_power_t power_state = dsgc_pkg::power_run;
	// the unused state code must fall back to the run word
	dsgc_pkg::dsgc_power_t pst [4] = '{dsgc_pkg::power_run, dsgc_pkg::power_sleep,
		dsgc_pkg::dsgc_power_t'(2'h3), dsgc_pkg::power_deep};
	logic [7:0]  pexp [4] = '{8'h3C, 8'h0F, 8'h3C, 8'hA5};
	dsgc_row_t   rows [14];
	dsgc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .pready,
		.prdata, .pslverr, .power_state, .port_access, .port_clock_enable, .port_bus_fault, .irq);
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// ********
	// tasks
	// ********
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop
	task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk_word
	task automatic chk_bit(input logic got, input logic exp);
		chk_word({31'h0000_0000, got}, {31'h0000_0000, exp});
	endtask : chk_bit
	// wait bound only guards against a hung slave
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (pready !== 1'b1) begin
			bad_count++;
			report_and_stop();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic fault_burst;
		port_access <= 8'hFF;
		@(posedge pclk);
		port_access <= 8'h00;
		@(posedge pclk);
	endtask : fault_burst
	// ********
	// sequence
	// ********
	initial begin
		rows = '{'{0, 12'h128, 0, 0, 0}, '{1, 12'h128, 32'hFFFF_FFA5, 0, 0},
			'{0, 12'h128, 0, 32'h0000_00A5, 0}, '{1, 12'h118, 32'h0000_000F, 0, 0},
			'{0, 12'h118, 0, 32'h0000_000F, 0}, '{1, 12'h108, 32'h0000_003C, 0, 0},
			'{0, 12'h108, 0, 32'h0000_003C, 0}, '{1, 12'h060, 32'h0000_0001, 0, 0},
			'{0, 12'h060, 0, 32'h0000_0001, 0}, '{1, 12'h204, 32'h0000_00FF, 0, 0},
			'{0, 12'h12C, 0, 0, 1}, '{1, 12'h12C, 32'h0000_00FF, 0, 1},
			'{0, 12'h128, 0, 32'h0000_00A5, 0}, '{0, 12'h200, 0, 0, 0}};
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (i = 0; i < 14; i++) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			if (!rows[i].w) chk_word(rd, rows[i].q);
			chk_bit(er, rows[i].e);
		end
		for (i = 0; i < 4; i++) begin
			power_state <= pst[i];
			repeat (3) @(posedge pclk);
			chk_word(32'(port_clock_enable), 32'(pexp[i]));
		end
		fault_burst();
		chk_word(32'(port_bus_fault), 32'h0000_005A);
		repeat (2) @(posedge pclk);
		chk_bit(irq, 1'b1);
		apb(1'b0, 12'h200, 0);
		chk_word(rd, 32'h0000_005A);
		apb(1'b1, 12'h200, 32'h0000_005A);
		repeat (2) @(posedge pclk);
		chk_bit(irq, 1'b0);
		apb(1'b1, 12'h204, 0);
		fault_burst();
		repeat (3) @(posedge pclk);
		chk_bit(irq, 1'b0);
		apb(1'b1, 12'h060, 0);
		repeat (3) @(posedge pclk);
		chk_word(32'(port_clock_enable), 32'h0000_003C);
		presetn <= 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		// a write without the low byte lane must leave the fields alone
		pstrb <= 4'hE;
		apb(1'b1, 12'h128, 32'h0000_00FF);
		chk_bit(er, 1'b0);
		pstrb <= 4'hF;
		apb(1'b0, 12'h128, 0);
		chk_word(rd, 32'h0000_0000);
		chk_word(32'(port_clock_enable), 32'h0000_0000);
		report_and_stop();
	end
endmodule : dsgc_top_tb
`default_nettype wire
